/* rtl/acis_pkg.sv */
/*
 * package for the auxiliary channel input select block: register map,
 * field positions, reset values and the routing code types.
 * assumes nothing of its surroundings.
 */
package acis_pkg;
	// register offsets on the axi4-lite bus, byte addresses
	localparam logic [3:0] ACIS_SELECT_OFFSET = 4'h0;
	localparam logic [3:0] ACIS_MODE_OFFSET = 4'h4;
	// field positions in the select register
	localparam int ACIS_NB_LSB = 9;
	localparam int ACIS_SB_BIT = 8;
	localparam int ACIS_NA_LSB = 1;
	localparam int ACIS_SA_BIT = 0;
	// field positions in the mode register
	localparam int ACIS_MODE_TWELVE_BIT = 0;
	localparam int ACIS_MODE_ALT_BIT = 1;
	localparam int ACIS_MODE_OPAMP_LSB = 4;
	// implemented bits of the select register and reset values
	localparam logic [15:0] ACIS_SELECT_MASK = 16'h0707;
	localparam logic [15:0] ACIS_SELECT_RESET = 16'h0000;
	localparam logic [6:0] ACIS_MODE_RESET = 7'h00;
	// stored bits of the mode register: twelve bit, alternate, three op amps
	localparam logic [6:0] ACIS_MODE_MASK = 7'h73;
	// negative select codes
	localparam logic [1:0] ACIS_NEG_HIGH = 2'h3;
	localparam logic [1:0] ACIS_NEG_MID = 2'h2;
	// axi responses
	localparam logic [1:0] ACIS_RESP_OKAY = 2'h0;
	localparam logic [1:0] ACIS_RESP_SLVERR = 2'h2;

	// source that an auxiliary channel input is routed to
	typedef enum logic [4:0] {
		ACIS_SRC_AN0, ACIS_SRC_AN1, ACIS_SRC_AN2, ACIS_SRC_AN3,
		ACIS_SRC_AN4, ACIS_SRC_AN5, ACIS_SRC_AN6, ACIS_SRC_AN7,
		ACIS_SRC_AN8, ACIS_SRC_AN9, ACIS_SRC_AN10, ACIS_SRC_AN11,
		ACIS_SRC_OA1, ACIS_SRC_OA2, ACIS_SRC_OA3, ACIS_SRC_VREFL
	} acis_src_t;

	// routing of one channel: positive and negative input
	typedef struct packed {
		acis_src_t pos;
		acis_src_t neg;
	} acis_route_t;

	// fields of one multiplexer setting
	typedef struct packed {
		logic [1:0] neg_sel;
		logic pos_sel;
	} acis_mux_t;
endpackage

/* rtl/acis_decode.sv */
/*
 * decode of one multiplexer setting into channel 1..3 routing.
 * assumes opamp_enable comes from logic on the same clock.
 */
`timescale 1ns/10ps
module acis_decode
	import acis_pkg::*;
(
	// setting and op amp state
	input wire acis_mux_t mux,
	input wire logic [2:0] opamp_enable,
	// routing per channel
	output acis_route_t route [3]
);
	// op amp output wins over its shared pin when enabled
	function automatic acis_src_t pick(input logic en, input acis_src_t oa,
		input acis_src_t an);
		pick = en ? oa : an; // see RL5
	endfunction

	// purely combinational; the caller registers the result
	always_comb begin
		// positive side; same decode for both muxes, see RL8
		if (mux.pos_sel) begin // see RL2
			route[0].pos = pick(opamp_enable[0], ACIS_SRC_OA1, ACIS_SRC_AN3);
			route[1].pos = pick(opamp_enable[1], ACIS_SRC_OA2, ACIS_SRC_AN0);
			route[2].pos = pick(opamp_enable[2], ACIS_SRC_OA3, ACIS_SRC_AN6);
		end else begin
			route[0].pos = pick(opamp_enable[1], ACIS_SRC_OA2, ACIS_SRC_AN0);
			route[1].pos = ACIS_SRC_AN1;
			route[2].pos = ACIS_SRC_AN2;
		end
		// negative side, see RL1 and RL3
		case (mux.neg_sel)
			ACIS_NEG_HIGH: begin
				route[0].neg = ACIS_SRC_AN9;
				route[1].neg = ACIS_SRC_AN10;
				route[2].neg = ACIS_SRC_AN11;
			end
			ACIS_NEG_MID: begin
				route[0].neg = pick(opamp_enable[2], ACIS_SRC_OA3, ACIS_SRC_AN6); // see RL7
				route[1].neg = ACIS_SRC_AN7;
				route[2].neg = ACIS_SRC_AN8;
			end
			default: begin
				route[0].neg = ACIS_SRC_VREFL;
				route[1].neg = ACIS_SRC_VREFL;
				route[2].neg = ACIS_SRC_VREFL;
			end
		endcase
	end
endmodule

/* rtl/acis_top.sv */
/*
 * auxiliary channel input select: axi4-lite register slave plus the
 * routing decode for converter channels 1, 2 and 3.
 * assumes one clock, a synchronous reset and a bus master on mclk.
 */
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/10ps
// Behaviour
// RL1 - mux b negative code 11 gives an9..11, 10 gives oa3/an6,an7,an8, 0x vrefl
// RL2 - mux b positive 1 gives oa1/an3,oa2/an0,oa3/an6; 0 gives oa2/an0,an1,an2
// RL3 - mux a negative code decodes exactly like mux b negative code
// RL4 - in twelve bit mode all select fields read zero and act as zero
// RL5 - a shared pin routes the op amp output when that op amp is enabled
// RL6 - select bits 15..11 and 7..3 store nothing and read zero
// RL7 - op amp substitution applies to all channel 1..3 routing choices
// RL8 - alternate control picks mux a or b setting; positive decode shared
module acis_top
	import acis_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// axi4-lite write address
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// converter sample phase: high selects the mux b setting when the alternate bit is set
	input wire logic sample_phase_b,
	// routing to the analog switches
	output acis_route_t channel_route [3]
);
	// registers
	logic [15:0] select_q, select_d;
	logic [6:0] mode_q, mode_d;
	// write channel state
	logic aw_held_q, aw_held_d;
	logic [3:0] aw_addr_q, aw_addr_d;
	logic w_held_q, w_held_d;
	logic [31:0] w_data_q, w_data_d;
	logic [3:0] w_strb_q, w_strb_d;
	logic bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;
	// read channel state
	logic rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0] rresp_q, rresp_d;
	// decode
	logic twelve_bit_resolution_mode;
	logic [2:0] opamp_enable;
	logic [15:0] select_view;
	acis_mux_t mux_a, mux_b, mux_live;
	acis_route_t route_next [3];
	acis_route_t route_q [3];
	logic do_write;

	assign twelve_bit_resolution_mode = mode_q[ACIS_MODE_TWELVE_BIT];
	assign opamp_enable = mode_q[ACIS_MODE_OPAMP_LSB +: 3];
	// fields vanish in twelve bit mode; storage kept so leaving it restores them
	assign select_view = twelve_bit_resolution_mode ? 16'h0000 : select_q; // see RL4

	// slave ready while its holding slot is empty and no response pending
	assign s_axi_awready = !aw_held_q && !bvalid_q;
	assign s_axi_wready = !w_held_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign channel_route = route_q;

	// write path: address and data may arrive in either order
	always_comb begin
		aw_held_d = aw_held_q;
		aw_addr_d = aw_addr_q;
		w_held_d = w_held_q;
		w_data_d = w_data_q;
		w_strb_d = w_strb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		select_d = select_q;
		mode_d = mode_q;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_held_d = 1'b1;
			aw_addr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_held_d = 1'b1;
			w_data_d = s_axi_wdata;
			w_strb_d = s_axi_wstrb;
		end
		do_write = aw_held_d && w_held_d && !bvalid_q;
		if (do_write) begin
			aw_held_d = 1'b0;
			w_held_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = ACIS_RESP_OKAY;
			case (aw_addr_d)
				ACIS_SELECT_OFFSET: begin
					// byte lanes apply separately; unimplemented bits drop, see RL6
					if (w_strb_d[0])
						select_d[7:0] = w_data_d[7:0] & ACIS_SELECT_MASK[7:0];
					if (w_strb_d[1])
						select_d[15:8] = w_data_d[15:8] & ACIS_SELECT_MASK[15:8];
				end
				ACIS_MODE_OFFSET: begin
					if (w_strb_d[0])
						mode_d = w_data_d[6:0] & ACIS_MODE_MASK; // see RL5
				end
				default: bresp_d = ACIS_RESP_SLVERR;
			endcase
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
	end

	// read path: one cycle from address to data
	always_comb begin
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_d = 1'b1;
			rresp_d = ACIS_RESP_OKAY;
			case (s_axi_araddr)
				ACIS_SELECT_OFFSET: rdata_d = {16'h0000, select_view}; // see RL4
				ACIS_MODE_OFFSET: rdata_d = {25'h0000000, mode_q};
				default: begin
					rdata_d = 32'h00000000;
					rresp_d = ACIS_RESP_SLVERR;
				end
			endcase
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
	end

	// choose the setting for the current sample, see RL8
	always_comb begin
		mux_a.neg_sel = select_view[ACIS_NA_LSB +: 2];
		mux_a.pos_sel = select_view[ACIS_SA_BIT];
		mux_b.neg_sel = select_view[ACIS_NB_LSB +: 2];
		mux_b.pos_sel = select_view[ACIS_SB_BIT];
		if (mode_q[ACIS_MODE_ALT_BIT] && sample_phase_b)
			mux_live = mux_b;
		else
			mux_live = mux_a;
	end

	// channel routing decode, op amp substitution inside, see RL7
	acis_decode u_decode (
		.mux(mux_live),
		.opamp_enable(opamp_enable),
		.route(route_next)
	);

	// software registers; reset leaves every op amp off and both muxes at zero
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			select_q <= ACIS_SELECT_RESET;
			mode_q <= ACIS_MODE_RESET;
		end else begin
			select_q <= select_d;
			mode_q <= mode_d;
		end
	end

	// write channel slots and the pending response
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			aw_held_q <= 1'b0;
			aw_addr_q <= 4'h0;
			w_held_q <= 1'b0;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= ACIS_RESP_OKAY;
		end else begin
			aw_held_q <= aw_held_d;
			aw_addr_q <= aw_addr_d;
			w_held_q <= w_held_d;
			w_data_q <= w_data_d;
			w_strb_q <= w_strb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
		end
	end

	// read answer; data held until the master takes it
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= ACIS_RESP_OKAY;
		end else begin
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	// routing register: switches never see a decode glitch, at one cycle of lag
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			for (int i = 0; i < 3; i++) begin
				route_q[i] <= '{pos: ACIS_SRC_AN0, neg: ACIS_SRC_VREFL};
			end
		end else begin
			route_q <= route_next;
		end
	end
endmodule

/* test/acis_props.sv */
/* checker for acis_top: bus handshakes and route codes.
   assumes it is bound into acis_top. */
`timescale 1ns/10ps
module acis_props
	import acis_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// routes
	input acis_route_t channel_route [3]
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_ar_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	property p_wr_resp; s_wr_taken |=> s_axi_bvalid; endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
	property p_b_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	a_b_block: assert property (p_b_block) else $error("write taken during answer");
	property p_rd_next; s_ar_taken |=> s_axi_rvalid; endproperty
	a_rd_next: assert property (p_rd_next) else $error("read answer late");
	property p_rd_block; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_rd_block: assert property (p_rd_block) else $error("read taken during answer");
	property p_rd_drop; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
	a_rd_drop: assert property (p_rd_drop) else $error("read answer stuck");
	property p_rd_zero;
		s_ar_taken ##0 (s_axi_araddr == ACIS_SELECT_OFFSET) |=>
			(s_axi_rdata & ~{16'h0, ACIS_SELECT_MASK}) == 32'h0;
	endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("empty bits read");
	// channel 1 negative: pin 6 or op amp 3, pin 9, or the low reference
	property p_neg_set;
		channel_route[0].neg inside {ACIS_SRC_AN6, ACIS_SRC_OA3, ACIS_SRC_AN9,
			ACIS_SRC_VREFL};
	endproperty
	a_neg_set: assert property (p_neg_set) else $error("bad negative route");
	property p_pos_ch2;
		channel_route[1].pos inside {ACIS_SRC_AN0, ACIS_SRC_OA2, ACIS_SRC_AN1};
	endproperty
	a_pos_ch2: assert property (p_pos_ch2) else $error("bad positive route");
endmodule
bind acis_top acis_props u_props (.mclk, .resetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .channel_route);

/* test/acis_switch_model.sv */
/* analog input switch model: one closed pair per channel.
   assumes routes come straight from acis_top. */
`timescale 1ns/10ps
module acis_switch_model
	import acis_pkg::*;
(
	// routes in
	input acis_route_t route [3],
	// closed pairs, channel 1 on top
	output logic [29:0] closed
);
	// switches add no delay of their own
	assign closed = {route[0], route[1], route[2]};
endmodule

/* test/adc_aux_channel_input_select_bench.sv */
/* self-checking bench for acis_top over axi4-lite.
   assumes nothing else drives the block. */
`timescale 1ns/10ps
module adc_aux_channel_input_select_bench
	import acis_pkg::*;
;
	logic mclk = 0, resetn = 0, awvalid = 0, wvalid = 0, arvalid = 0, ph = 0;
	logic bready = 1, rready = 1;
	logic [3:0] awaddr = 0, araddr = 0;
	logic [3:0] strb = 4'hf;
	logic [31:0] wdata = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [29:0] sw;
	acis_route_t route [3];
	int mismatches = 0, checks = 0, seed = 49;
	logic [33:0] q[$];
	always #2.5 mclk = ~mclk;
	acis_top dut (.mclk(mclk), .resetn(resetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .sample_phase_b(ph), .channel_route(route));
	acis_switch_model sw_model (.route(route), .closed(sw));
	task automatic check(input logic [33:0] got, input logic [33:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic hang;
		mismatches++;
		$display("mismatch at %0t: no answer", $time);
		finish_test();
	endtask
	// address and data offered together, each dropped once taken
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge mclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		if (n == 40) hang();
		check(bresp, r);
	endtask
	task automatic rd(input logic [3:0] a, input logic [33:0] e);
		int n;
		q.push_back(e);
		araddr <= a;
		arvalid <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge mclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		if (n == 40) hang();
	endtask
	// read answers are matched to the oldest note
	always @(posedge mclk) begin
		if (rvalid && rready && q.size() > 0) begin
			check({rresp, rdata}, q.pop_front());
		end else if (rvalid && rready) begin
			mismatches++;
			$display("mismatch at %0t: read answer with no note", $time);
		end
	end
	// expected routing built from the select tables and op amp states
	function automatic logic [29:0] er(input logic [15:0] s, input logic [6:0] m,
		input logic p);
		logic [2:0] f;
		logic [14:0] ps, ns;
		acis_src_t a, b, c;
		f = m[0] ? 3'h0 : (m[1] && p) ? s[10:8] : s[2:0];
		a = m[4] ? ACIS_SRC_OA1 : ACIS_SRC_AN3;
		b = m[5] ? ACIS_SRC_OA2 : ACIS_SRC_AN0;
		c = m[6] ? ACIS_SRC_OA3 : ACIS_SRC_AN6;
		ps = f[0] ? {a, b, c} : {b, ACIS_SRC_AN1, ACIS_SRC_AN2};
		ns = (f[2:1] == 2'h3) ? {ACIS_SRC_AN9, ACIS_SRC_AN10, ACIS_SRC_AN11} :
			f[2] ? {c, ACIS_SRC_AN7, ACIS_SRC_AN8} : {3{ACIS_SRC_VREFL}};
		er = {ps[14:10], ns[14:10], ps[9:5], ns[9:5], ps[4:0], ns[4:0]};
	endfunction
	initial begin
		logic [15:0] s;
		logic [6:0] m;
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		wr(4'h8, 32'hffff, ACIS_RESP_SLVERR);
		rd(ACIS_SELECT_OFFSET, 34'h0);
		rd(4'hc, {ACIS_RESP_SLVERR, 32'h0});
		for (int i = 0; i < 16; i++) begin
			s = 16'($random(seed));
			s[10:9] = i[1:0];
			s[2:1] = i[3:2];
			m = 7'($random(seed)) & ACIS_MODE_MASK;
			m[0] = i[0] & i[2];
			wr(ACIS_MODE_OFFSET, {25'h0, m}, ACIS_RESP_OKAY);
			wr(ACIS_SELECT_OFFSET, {16'h0, s}, ACIS_RESP_OKAY);
			ph <= 1'($random(seed));
			repeat (2) @(posedge mclk);
			check(sw, er(s, m, ph));
			rd(ACIS_SELECT_OFFSET, {ACIS_RESP_OKAY, 16'h0, m[0] ? 16'h0 : s & ACIS_SELECT_MASK});
			rd(ACIS_MODE_OFFSET, {ACIS_RESP_OKAY, 25'h0, m});
			$display("test %0d done", i);
		end
		// byte lanes land separately, empty bits stay zero
		wr(ACIS_MODE_OFFSET, 32'h0, ACIS_RESP_OKAY);
		wr(ACIS_SELECT_OFFSET, 32'h0, ACIS_RESP_OKAY);
		strb <= 4'h2;
		wr(ACIS_SELECT_OFFSET, 32'hffff, ACIS_RESP_OKAY);
		rd(ACIS_SELECT_OFFSET, {ACIS_RESP_OKAY, 32'h0700});
		strb <= 4'h1;
		wr(ACIS_SELECT_OFFSET, 32'hffff, ACIS_RESP_OKAY);
		rd(ACIS_SELECT_OFFSET, {ACIS_RESP_OKAY, 32'h0707});
		strb <= 4'hf;
		$display("test lanes done");
		// reset in mid-run clears both registers and the routing
		wr(ACIS_MODE_OFFSET, 32'h73, ACIS_RESP_OKAY);
		resetn <= 1'b0;
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		repeat (2) @(posedge mclk);
		check(sw, er(16'h0, 7'h0, 1'b0));
		rd(ACIS_SELECT_OFFSET, {ACIS_RESP_OKAY, 32'h0});
		rd(ACIS_MODE_OFFSET, {ACIS_RESP_OKAY, 32'h0});
		$display("test reset done");
		repeat (2) @(posedge mclk);
		finish_test();
	end
endmodule
